//--- hw/cpwm_core.v
// counter pwm generation and a/b capture block with an avalon-mm register slave
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "cpwm_defines.vh"

module cpwm_core #(
	parameter DATA_W = 32,
	parameter ADDR_W = 6
) (
	input  wire              sys_clk,
	input  wire              rst_n,
	input  wire              cnt_tick,
	input  wire              tap_1k,
	input  wire              tap_16k,
	input  wire              capture_pin_two,
	input  wire              capture_pin_three,
	input  wire [ADDR_W-1:0] avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [DATA_W-1:0] avs_writedata,
	input  wire [3:0]        avs_byteenable,
	output reg  [DATA_W-1:0] avs_readdata,
	output wire              avs_waitrequest,
	output reg               port_out_pin_zero,
	output reg               port_out_pin_one,
	output reg               counter_a_interrupt,
	output reg               counter_b_interrupt
);

	// one step of an eight bit counter, wrapping both ways
	function [7:0] step8;
		input [7:0] val;
		input       up;
		begin
			step8 = up ? val + 8'h01 : val - 8'h01;
		end
	endfunction

	// one step of a cascaded pair, wrapping at zero and 0xffff
	function [15:0] step16;
		input [15:0] val;
		input        up;
		begin
			step16 = up ? val + 16'h0001 : val - 16'h0001;
		end
	endfunction

	// mask of the counter bits that form the pwm period
	function [15:0] size_mask;
		input [1:0] size;
		begin
			case (size)
				2'h3:    size_mask = 16'hffff;
				2'h2:    size_mask = 16'h3fff;
				2'h1:    size_mask = 16'h0fff;
				default: size_mask = 16'h03ff;
			endcase
		end
	endfunction

	// pwm level: count masked to the resolution compared with the code
	function pwm_level;
		input [15:0] count;
		input [15:0] code;
		input [15:0] mask;
		begin
			pwm_level = ((count & mask) <= code);
		end
	endfunction

	reg  [7:0]  counter_config_first;
	reg  [7:0]  counter_config_second;
	reg  [3:0]  counter_run;
	reg  [7:0]  code_a;
	reg  [7:0]  code_b;
	reg  [7:0]  code_c;
	reg  [7:0]  code_d;
	reg  [1:0]  portb_output_value;
	reg  [7:0]  cnt_a;
	reg  [7:0]  cnt_b;
	reg  [7:0]  cnt_c;
	reg  [7:0]  cnt_d;
	reg  [7:0]  shadow_a;
	reg  [7:0]  shadow_b;
	reg         capture_pending;
	reg         capture_seen;
	reg         cap_prev;
	reg         cap_now;
	reg         pin_two_meta;
	reg         pin_two_sync;
	reg         pin_three_meta;
	reg         pin_three_sync;
	reg         pwm_ab_q;
	reg         pwm_cd_q;
	reg         bus_ack;
	reg  [7:0]  next_read;

	wire        join_pair_low        = counter_config_first[`CPWM_JOIN_LOW];
	wire        join_pair_high       = counter_config_first[`CPWM_JOIN_HIGH];
	wire        pwm_select_pair_ab   = counter_config_first[`CPWM_PWM_AB];
	wire        pwm_select_pair_cd   = counter_config_first[`CPWM_PWM_CD];
	wire [1:0]  resolution_size_ab   = counter_config_second[`CPWM_SIZE_AB_LSB +: 2];
	wire [1:0]  resolution_size_cd   = counter_config_second[`CPWM_SIZE_CD_LSB +: 2];
	wire [1:0]  capture_edge_select  = counter_config_second[`CPWM_EDGE_LSB +: 2];
	wire [1:0]  capture_source_select = counter_config_second[`CPWM_SRC_LSB +: 2];
	wire        capture_on           = (capture_edge_select != `CPWM_EDGE_OFF);
	wire        bus_req              = avs_read | avs_write;
	wire        bus_write            = avs_write & bus_ack & avs_byteenable[0];
	wire        pwm_ab;
	wire        pwm_cd;
	wire        cap_edge;
	reg         cap_source;

	// every access waits one cycle, so read data can come from a flop
	assign avs_waitrequest = bus_req & ~bus_ack;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// register writes land on the cycle that waitrequest is low
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_config_first  <= `CPWM_RST_CONFIG;
			counter_config_second <= `CPWM_RST_CONFIG;
			counter_run           <= 4'h0;
			code_a                <= `CPWM_RST_CODE;
			code_b                <= `CPWM_RST_CODE;
			code_c                <= `CPWM_RST_CODE;
			code_d                <= `CPWM_RST_CODE;
			portb_output_value    <= 2'h0;
		end else if (bus_write) begin
			case (avs_address)
				`CPWM_OFS_CONFIG_FIRST:  counter_config_first  <= avs_writedata[7:0];
				`CPWM_OFS_CONFIG_SECOND: counter_config_second <= avs_writedata[7:0];
				`CPWM_OFS_RUN:           counter_run           <= avs_writedata[3:0];
				`CPWM_OFS_CODE_A:        code_a                <= avs_writedata[7:0];
				`CPWM_OFS_CODE_B:        code_b                <= avs_writedata[7:0];
				`CPWM_OFS_CODE_C:        code_c                <= avs_writedata[7:0];
				`CPWM_OFS_CODE_D:        code_d                <= avs_writedata[7:0];
				`CPWM_OFS_PORTB_OUT:     portb_output_value    <= avs_writedata[1:0];
				default: begin
				end
			endcase
		end
	end

	// read mux; a/b read the shadow while capture is on
	always @* begin
		case (avs_address)
			`CPWM_OFS_CONFIG_FIRST:  next_read = counter_config_first;
			`CPWM_OFS_CONFIG_SECOND: next_read = counter_config_second;
			`CPWM_OFS_RUN:           next_read = {4'h0, counter_run};
			`CPWM_OFS_CODE_A:        next_read = capture_on ? shadow_a : cnt_a;
			`CPWM_OFS_CODE_B:        next_read = capture_on ? shadow_b : cnt_b;
			`CPWM_OFS_CODE_C:        next_read = cnt_c;
			`CPWM_OFS_CODE_D:        next_read = cnt_d;
			`CPWM_OFS_PORTB_OUT:     next_read = {6'h00, portb_output_value};
			`CPWM_OFS_STATUS:        next_read = {5'h00, capture_pending, pwm_cd_q, pwm_ab_q};
			default:                 next_read = 8'h00;
		endcase
	end

	// data is caught in the wait cycle and stands at the completing edge
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= {DATA_W{1'b0}};
		end else if (avs_read & ~bus_ack) begin
			avs_readdata <= {{(DATA_W-8){1'b0}}, next_read};
		end
	end

	// pins come from another domain, two flops before any use
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_two_meta   <= 1'b0;
			pin_two_sync   <= 1'b0;
			pin_three_meta <= 1'b0;
			pin_three_sync <= 1'b0;
		end else begin
			pin_two_meta   <= capture_pin_two;
			pin_two_sync   <= pin_two_meta;
			pin_three_meta <= capture_pin_three;
			pin_three_sync <= pin_three_meta;
		end
	end

	// capture source mux; prescaler taps are already on this clock
	always @* begin
		case (capture_source_select)
			`CPWM_SRC_TAP_1K:    cap_source = tap_1k;
			`CPWM_SRC_TAP_16K:   cap_source = tap_16k;
			`CPWM_SRC_PIN_THREE: cap_source = pin_three_sync;
			default:             cap_source = pin_two_sync;
		endcase
	end

	// the source is sampled only on counter ticks, so a level must last
	// at least one counter tick period to be seen as an edge
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_now  <= 1'b0;
			cap_prev <= 1'b0;
		end else if (cnt_tick) begin
			cap_now  <= cap_source;
			cap_prev <= cap_now;
		end
	end

	// edge qualification by the edge field
	assign cap_edge = capture_seen &
		(((capture_edge_select == `CPWM_EDGE_RISE) & cap_now & ~cap_prev) |
		 ((capture_edge_select == `CPWM_EDGE_FALL) & ~cap_now & cap_prev) |
		 ((capture_edge_select == `CPWM_EDGE_BOTH) & (cap_now ^ cap_prev)));

	// shadow load at the tick after the edge, interrupt one tick later;
	// one shared condition for a and b keeps the pair coherent
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_a            <= `CPWM_RST_COUNT;
			shadow_b            <= `CPWM_RST_COUNT;
			capture_pending     <= 1'b0;
			capture_seen        <= 1'b0;
			counter_a_interrupt <= 1'b0;
			counter_b_interrupt <= 1'b0;
		end else begin
			counter_a_interrupt <= 1'b0;
			counter_b_interrupt <= 1'b0;
			if (cnt_tick) begin
				// first tick after enabling only primes the edge history
				capture_seen    <= capture_on;
				capture_pending <= 1'b0;
				if (capture_pending) begin
					counter_a_interrupt <= 1'b1;
					counter_b_interrupt <= 1'b1;
				end
				if (cap_edge) begin
					shadow_a        <= cnt_a;
					shadow_b        <= cnt_b;
					capture_pending <= 1'b1;
				end
			end
		end
	end

	// counters a/b: independent bytes or one 16-bit pair, a is the low byte;
	// plain counter mode events are not generated here, so only capture
	// raises the counter interrupts and pwm mode raises none
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_a <= `CPWM_RST_COUNT;
			cnt_b <= `CPWM_RST_COUNT;
		end else if (cnt_tick) begin
			if (join_pair_low) begin
				if (counter_run[0]) begin
					{cnt_b, cnt_a} <= step16({cnt_b, cnt_a},
						counter_config_first[`CPWM_DIR_A]);
				end
			end else begin
				if (counter_run[0]) begin
					cnt_a <= step8(cnt_a, counter_config_first[`CPWM_DIR_A]);
				end
				if (counter_run[1]) begin
					cnt_b <= step8(cnt_b, counter_config_first[`CPWM_DIR_B]);
				end
			end
		end
	end

	// counters c/d, same structure, c is the low byte
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_c <= `CPWM_RST_COUNT;
			cnt_d <= `CPWM_RST_COUNT;
		end else if (cnt_tick) begin
			if (join_pair_high) begin
				if (counter_run[2]) begin
					{cnt_d, cnt_c} <= step16({cnt_d, cnt_c},
						counter_config_first[`CPWM_DIR_C]);
				end
			end else begin
				if (counter_run[2]) begin
					cnt_c <= step8(cnt_c, counter_config_first[`CPWM_DIR_C]);
				end
				if (counter_run[3]) begin
					cnt_d <= step8(cnt_d, counter_config_first[`CPWM_DIR_D]);
				end
			end
		end
	end

	// masking the count sets the period to two to the resolution; a code
	// above the mask can never be reached, so the level stays high
	assign pwm_ab = join_pair_low ?
		pwm_level({cnt_b, cnt_a}, {code_b, code_a}, size_mask(resolution_size_ab)) :
		pwm_level({8'h00, cnt_a}, {8'h00, code_a}, {8'h00, `CPWM_MAX8});
	assign pwm_cd = join_pair_high ?
		pwm_level({cnt_d, cnt_c}, {code_d, code_c}, size_mask(resolution_size_cd)) :
		pwm_level({8'h00, cnt_c}, {8'h00, code_c}, {8'h00, `CPWM_MAX8});

	// resampled on the counter tick to strip compare glitches
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_ab_q <= 1'b0;
			pwm_cd_q <= 1'b0;
		end else if (cnt_tick) begin
			pwm_ab_q <= pwm_ab;
			pwm_cd_q <= pwm_cd;
		end
	end

	// port b bits: pwm overrides the software value; pin mode and drive
	// type stay with the port b block outside
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_out_pin_zero <= 1'b0;
			port_out_pin_one  <= 1'b0;
		end else begin
			port_out_pin_zero <= pwm_select_pair_ab ? pwm_ab_q : portb_output_value[0];
			port_out_pin_one  <= pwm_select_pair_cd ? pwm_cd_q : portb_output_value[1];
		end
	end

endmodule

//--- hw/cpwm_defines.vh
// register map, field positions, reset values and timing for the counter pwm/capture block
`ifndef CPWM_DEFINES_VH
`define CPWM_DEFINES_VH

// byte offsets of the word-aligned registers
`define CPWM_OFS_CONFIG_FIRST   6'h00
`define CPWM_OFS_CONFIG_SECOND  6'h04
`define CPWM_OFS_RUN            6'h08
`define CPWM_OFS_CODE_A         6'h0c
`define CPWM_OFS_CODE_B         6'h10
`define CPWM_OFS_CODE_C         6'h14
`define CPWM_OFS_CODE_D         6'h18
`define CPWM_OFS_PORTB_OUT      6'h1c
`define CPWM_OFS_STATUS         6'h20

// counter_config_first fields
`define CPWM_DIR_A              0
`define CPWM_DIR_B              1
`define CPWM_DIR_C              2
`define CPWM_DIR_D              3
`define CPWM_JOIN_LOW           4
`define CPWM_JOIN_HIGH          5
`define CPWM_PWM_AB             6
`define CPWM_PWM_CD             7

// counter_config_second fields (low bit of each two-bit field)
`define CPWM_SIZE_AB_LSB        0
`define CPWM_SIZE_CD_LSB        2
`define CPWM_EDGE_LSB           4
`define CPWM_SRC_LSB            6

// encodings
`define CPWM_EDGE_OFF           2'h0
`define CPWM_EDGE_RISE          2'h1
`define CPWM_EDGE_FALL          2'h2
`define CPWM_EDGE_BOTH          2'h3
`define CPWM_SRC_PIN_TWO        2'h0
`define CPWM_SRC_PIN_THREE      2'h1
`define CPWM_SRC_TAP_16K        2'h2
`define CPWM_SRC_TAP_1K         2'h3

// reset values and the eight-bit count maximum
`define CPWM_RST_CONFIG         8'h00
`define CPWM_RST_CODE           8'h00
`define CPWM_RST_COUNT          8'h00
`define CPWM_MAX8               8'hff

// bus answer: one wait cycle before every access completes
`define CPWM_WAIT_CYCLES        1

`endif

//--- sim/cpwm_core_monitor.sv
// port assertions for the counter pwm/capture block
`timescale 1ns/1ns
module cpwm_core_monitor #(
	parameter DATA_W = 32
) (
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              cnt_tick,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic              avs_waitrequest,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic              port_out_pin_zero,
	input wire logic              port_out_pin_one,
	input wire logic              counter_a_interrupt,
	input wire logic              counter_b_interrupt
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a request still waiting for its answer
	sequence req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// no register write that could move a pin lately
	sequence bus_quiet;
		!$past(avs_write, 1) && !$past(avs_write, 2) && !$past(avs_write, 3);
	endsequence
	chk_bus_one_wait: assert property (req_wait |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	chk_bus_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without a wait cycle");
	chk_bus_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without a request");
	chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[DATA_W-1:8] == '0)
		else $error("read data upper bits not zero");
	chk_irq_pair_same: assert property (counter_a_interrupt == counter_b_interrupt)
		else $error("capture interrupts a and b differ");
	chk_irq_one_pulse: assert property (counter_a_interrupt |=> !counter_a_interrupt)
		else $error("capture interrupt longer than one cycle");
	chk_irq_after_tick: assert property ($rose(counter_a_interrupt) |-> $past(cnt_tick))
		else $error("capture interrupt not on a counter tick");
	chk_pin_zero_tick: assert property ($changed(port_out_pin_zero) ##0 bus_quiet |-> $past(cnt_tick, 2))
		else $error("pin zero moved off the counter clock");
	chk_pin_one_tick: assert property ($changed(port_out_pin_one) ##0 bus_quiet |-> $past(cnt_tick, 2))
		else $error("pin one moved off the counter clock");
	cov_capture: cover property ($rose(counter_a_interrupt));
endmodule

bind cpwm_core cpwm_core_monitor #(.DATA_W(DATA_W)) u_cpwm_core_monitor (
	.sys_clk(sys_clk), .rst_n(rst_n), .cnt_tick(cnt_tick), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.port_out_pin_zero(port_out_pin_zero), .port_out_pin_one(port_out_pin_one),
	.counter_a_interrupt(counter_a_interrupt), .counter_b_interrupt(counter_b_interrupt));

//--- sim/cpwm_core_tb.sv
// self-checking bench for the counter pwm/capture block
`timescale 1ns/1ns
`include "cpwm_defines.vh"
module cpwm_core_tb;
	logic        sys_clk = 0, rst_n = 0, cnt_tick = 0, cap_two = 0, cap_three = 0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, rd2;
	logic        avs_waitrequest, pin_zero, pin_one, irq_a, irq_b, tap_1k, tap_16k;
	logic        start = 0, sel = 0, done, irq_seen = 0;
	logic [16:0] span = 17'h0, high_cnt;
	logic [15:0] code;
	int          fail_count = 0, comparisons = 0, cyc = 0, i, j;
	logic [1:0]  edg [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	cpwm_core u_cpwm_core (.sys_clk(sys_clk), .rst_n(rst_n), .cnt_tick(cnt_tick),
		.tap_1k(tap_1k), .tap_16k(tap_16k), .capture_pin_two(cap_two),
		.capture_pin_three(cap_three), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.port_out_pin_zero(pin_zero), .port_out_pin_one(pin_one),
		.counter_a_interrupt(irq_a), .counter_b_interrupt(irq_b));
	cpwm_pins_model u_cpwm_pins_model (.sys_clk(sys_clk), .rst_n(rst_n), .cnt_tick(cnt_tick),
		.port_out_pin_zero(pin_zero), .port_out_pin_one(pin_one), .start(start), .sel(sel),
		.span(span), .tap_1k(tap_1k), .tap_16k(tap_16k), .high_cnt(high_cnt), .done(done));
	always #5 sys_clk = ~sys_clk;
	// counter clock enable every second cycle, interrupt catcher and hang guard
	always @(posedge sys_clk) begin
		cnt_tick <= ~cnt_tick;
		if (irq_a === 1'b1) irq_seen <= 1'b1;
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one avalon transfer: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_write <= w; avs_read <= !w; avs_address <= a; avs_writedata <= {24'h0, d};
		// waitrequest sampled at each rising edge; no timeout here, a stuck wait is ended only by the bench timeout
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0; avs_read <= 1'b0;
	endtask
	// high ticks expected over one period: code+1, all of it when code is out of range
	function automatic logic [16:0] exp_high(input logic [15:0] c, input int res);
		logic [16:0] top;
		top = 17'h1 << res;
		exp_high = ({1'b0, c} >= top - 17'h1) ? top : {1'b0, c} + 17'h1;
	endfunction
	task automatic meas(input logic s, input int res, input logic [15:0] c);
		int k;
		repeat (30) @(posedge sys_clk);
		start <= 1'b1; sel <= s; span <= 17'h1 << res;
		@(posedge sys_clk);
		start <= 1'b0;
		for (k = 0; k < (4 << res) + 20; k++) begin
			@(negedge sys_clk);
			if (done === 1'b1) break;
		end
		check({15'h0, high_cnt}, {15'h0, exp_high(c, res)});
	endtask
	task automatic end_of_test();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(6));
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(0, `CPWM_OFS_CONFIG_FIRST, 8'h00);
		check(rd, 32'h0);
		check({pin_one, pin_zero}, 2'h0);
		// software value reaches the pins while pwm is off
		bus(1, `CPWM_OFS_PORTB_OUT, 8'h02);
		repeat (4) @(posedge sys_clk);
		check({pin_one, pin_zero}, 2'h2);
		bus(1, `CPWM_OFS_RUN, 8'h0f);
		// eight-bit pwm on a, size field set to 16 bits but ignored
		bus(1, `CPWM_OFS_CONFIG_SECOND, 8'h03);
		for (i = 0; i < 4; i++) begin
			code = (i == 0) ? 16'h0 : (i == 1) ? 16'hff : 16'($urandom % 256);
			bus(1, `CPWM_OFS_CONFIG_FIRST, 8'h40 | 8'($urandom % 2));
			bus(1, `CPWM_OFS_CODE_A, code[7:0]);
			meas(0, 8, code);
		end
		check(pin_one, 1'b1);
		// cascaded c/d at 10 and 12 bits, in and out of range
		for (i = 0; i < 2; i++) begin
			for (j = 0; j < 2; j++) begin
				code = 16'($urandom % (1 << (10 + 2 * i))) | (j ? 16'h1 << (10 + 2 * i) : 16'h0);
				bus(1, `CPWM_OFS_CONFIG_FIRST, 8'ha0 | (8'($urandom % 2) << 2));
				bus(1, `CPWM_OFS_CONFIG_SECOND, 8'(i << 2));
				bus(1, `CPWM_OFS_CODE_C, code[7:0]);
				bus(1, `CPWM_OFS_CODE_D, code[15:8]);
				meas(1, 10 + 2 * i, code);
			end
		end
		// capture for each source with its own edge setting, the 1k tap with edge off, while a generates pwm
		bus(1, `CPWM_OFS_CONFIG_FIRST, 8'h41);
		for (i = 0; i < 4; i++) begin
			bus(1, `CPWM_OFS_RUN, 8'h00);
			bus(1, `CPWM_OFS_CONFIG_SECOND, {2'(i), edg[i], 4'h0});
			bus(1, `CPWM_OFS_RUN, 8'h0f);
			irq_seen <= 1'b0;
			repeat (20) @(posedge sys_clk);
			cap_two <= 1'b1; cap_three <= 1'b1;
			repeat (20) @(posedge sys_clk);
			cap_two <= 1'b0; cap_three <= 1'b0;
			repeat (1200) @(posedge sys_clk);
			check(irq_seen, edg[i] != 2'h0);
			if (i == 0) begin
				bus(0, `CPWM_OFS_CODE_A, 8'h00);
				rd2 = rd;
				repeat (9) @(posedge sys_clk);
				bus(0, `CPWM_OFS_CODE_A, 8'h00);
				check(rd, rd2);
			end
		end
		end_of_test();
	end
endmodule

//--- sim/cpwm_pins_model.sv
// far side: prescaler taps and a pwm high-time meter on the port b pins
`timescale 1ns/1ns
module cpwm_pins_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        cnt_tick,
	input  wire logic        port_out_pin_zero,
	input  wire logic        port_out_pin_one,
	input  wire logic        start,
	input  wire logic        sel,
	input  wire logic [16:0] span,
	output wire logic        tap_1k,
	output wire logic        tap_16k,
	output logic      [16:0] high_cnt,
	output logic             done
);
	logic [8:0]  div;
	logic [16:0] left;
	// taps keep the 1:16 ratio, scaled down; each level lasts many ticks
	assign tap_16k = div[4];
	assign tap_1k  = div[8];
	// pins are taken as plain push-pull outputs, as software set them
	// meter counts the ticks on which the selected pin is high, over span ticks
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 9'h000; left <= 17'h0; high_cnt <= 17'h0; done <= 1'b0;
		end else begin
			div <= div + 9'h001;
			if (start) begin
				left <= span; high_cnt <= 17'h0; done <= 1'b0;
			end else if (cnt_tick && left != 17'h0) begin
				left <= left - 17'h1;
				high_cnt <= high_cnt + {16'h0, sel ? port_out_pin_one : port_out_pin_zero};
				done <= (left == 17'h1);
			end
		end
	end
endmodule
